// ===== core/bit_timer.sv
// Basic 8-bit interval timer with APB registers, interrupt and green wake
`timescale 1ns/100ps
`default_nettype none
module bit_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fcpu_tick,
  input wire logic xtal32k_tick,
  input wire logic green_mode,
  input wire logic internal_rc_with_rtc_option,
  output logic irq,
  output logic [15:0] irq_vector,
  output logic wake_req
);

  // Prescale code to divide ratio: 000 -> 256 ... 111 -> 2
  function automatic logic [8:0] rate_divisor(input logic [2:0] code);
    rate_divisor = bit_pkg::DIV_SLOWEST >> code;
  endfunction : rate_divisor

  // Address match used by the write decode; the read mux cases on paddr directly
  function automatic logic hit(input logic [11:0] a, input logic [11:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit

  // Mode register fields
  logic timer_run_enable_q;
  logic [2:0] prescale_select_q;
  logic rtc_source_select_q;

  // Counter and pending software load
  logic [7:0] count_value_q;
  logic load_pend_q;
  logic [7:0] load_val_q;

  // Event, interrupt and strap state
  logic overflow_flag_q;
  logic overflow_irq_enable_q;
  logic rtc_option_q;
  logic strap_done_q;

  // Bus answer flops, plus interrupt, vector and wake output flops
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [15:0] irq_vector_q;
  logic wake_q;

  // Combinational helpers
  logic setup_phase;
  logic wr_fire;
  logic wr_low;
  logic mode_we;
  logic count_we;
  logic clear_we;
  logic enable_we;
  logic src_tick;
  logic [8:0] divisor;
  logic timer_tick;
  logic ovf_evt;
  logic mapped;
  logic [31:0] rd_mux;

  // Bus phase decode; a write lands only at the completing edge
  assign setup_phase = psel && !penable;
  assign wr_fire = psel && penable && pwrite && pready_q;
  assign wr_low = wr_fire && pstrb[0];
  assign mode_we = wr_low && hit(paddr, bit_pkg::ADDR_MODE);
  assign count_we = wr_low && hit(paddr, bit_pkg::ADDR_COUNT);
  assign clear_we = wr_low && hit(paddr, bit_pkg::ADDR_CLEAR);
  assign enable_we = wr_low && hit(paddr, bit_pkg::ADDR_ENABLE);

  // Source and ratio; crystal mode bypasses the prescale field
  assign src_tick = rtc_source_select_q ? xtal32k_tick : fcpu_tick;
  assign divisor = rtc_source_select_q ? bit_pkg::RTC_DIV
                                       : rate_divisor(prescale_select_q);

  bit_prescaler #(
    .DIV_W(bit_pkg::DIV_W)
  ) u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .src_tick(src_tick),
    .run(timer_run_enable_q),
    .divisor(divisor),
    .tick_out(timer_tick)
  );

  // Wrap from full scale, unless a pending load replaces the step
  assign ovf_evt = timer_tick && !load_pend_q
                   && (count_value_q == bit_pkg::COUNT_FULL);

  // Option strap is caught once after reset release, never under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rtc_option_q <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      rtc_option_q <= internal_rc_with_rtc_option;
      strap_done_q <= 1'b1;
    end
  end

  // Mode register; the crystal bit sticks at 0 without the RTC option
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_run_enable_q <= bit_pkg::MODE_RESET[bit_pkg::MODE_RUN_BIT];
      prescale_select_q <= bit_pkg::MODE_RESET[bit_pkg::MODE_RATE_HI:bit_pkg::MODE_RATE_LO];
      rtc_source_select_q <= bit_pkg::MODE_RESET[bit_pkg::MODE_RTC_BIT];
    end else if (mode_we) begin
      timer_run_enable_q <= pwdata[bit_pkg::MODE_RUN_BIT];
      prescale_select_q <= pwdata[bit_pkg::MODE_RATE_HI:bit_pkg::MODE_RATE_LO];
      rtc_source_select_q <= pwdata[bit_pkg::MODE_RTC_BIT] && rtc_option_q;
    end
  end

  // Count writes while running wait for the next timer clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_pend_q <= 1'b0;
      load_val_q <= bit_pkg::COUNT_RESET;
    end else if (count_we && timer_run_enable_q) begin
      load_pend_q <= 1'b1;
      load_val_q <= pwdata[7:0];
    end else if (timer_tick || !timer_run_enable_q) begin
      load_pend_q <= 1'b0;
    end
  end

  // Counter: loads while stopped take effect at once, else per tick
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_q <= bit_pkg::COUNT_RESET;
    end else if (count_we && !timer_run_enable_q) begin
      count_value_q <= pwdata[7:0];
    end else if (!timer_run_enable_q && load_pend_q) begin
      count_value_q <= load_val_q;
    end else if (timer_tick) begin
      // Ticks come in every power mode; green mode just gates the CPU
      if (load_pend_q) begin
        count_value_q <= load_val_q;
      end else begin
        count_value_q <= count_value_q + 8'h01;
      end
    end
    // No tick while stopped: value simply holds
  end

  // Overflow flag; a new overflow beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_q <= 1'b0;
    end else if (ovf_evt) begin
      overflow_flag_q <= 1'b1;
    end else if (clear_we && pwdata[bit_pkg::EVT_OVF_BIT]) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // Interrupt enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_irq_enable_q <= 1'b0;
    end else if (enable_we) begin
      overflow_irq_enable_q <= pwdata[bit_pkg::EVT_OVF_BIT];
    end
  end

  // Level interrupt and its fixed vector
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
      irq_vector_q <= bit_pkg::IRQ_VECTOR;
    end else begin
      irq_q <= overflow_flag_q && overflow_irq_enable_q;
      irq_vector_q <= bit_pkg::IRQ_VECTOR;
    end
  end

  // Wake pulse on overflow in green mode; the system restores its mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= ovf_evt && green_mode;
    end
  end

  // Read data; reserved mode bits and the clear register read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr)
      bit_pkg::ADDR_MODE: begin
        rd_mux[bit_pkg::MODE_RUN_BIT] = timer_run_enable_q;
        rd_mux[bit_pkg::MODE_RATE_HI:bit_pkg::MODE_RATE_LO] = prescale_select_q;
        rd_mux[bit_pkg::MODE_RTC_BIT] = rtc_source_select_q;
      end
      bit_pkg::ADDR_COUNT: begin
        rd_mux[7:0] = count_value_q;
      end
      bit_pkg::ADDR_STATUS: begin
        rd_mux[bit_pkg::EVT_OVF_BIT] = overflow_flag_q;
      end
      bit_pkg::ADDR_CLEAR: begin
        rd_mux = 32'h0000_0000;
      end
      bit_pkg::ADDR_ENABLE: begin
        rd_mux[bit_pkg::EVT_OVF_BIT] = overflow_irq_enable_q;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end

  // One wait-free access cycle: answer prepared during setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (setup_phase) begin
      pready_q <= 1'b1;
      pslverr_q <= !mapped;
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  // All outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;
  assign irq_vector = irq_vector_q;
  assign wake_req = wake_q;

endmodule : bit_timer
`default_nettype wire

// ===== pkg/bit_pkg.sv
// Constants of the basic 8-bit interval timer: map, fields, resets, rates
//Function
//- counter advances only while the run-enable bit in the mode register is set
//- count value is an 8-bit, 256-step register stepping once per timer clock
//- overflow is the wrap of the count value from 0xFF to 0x00
//- every overflow sets the overflow flag; only software clears it
//- enabled overflow raises the interrupt to vector 000BH; handler clears the flag
//- in green mode timer keeps counting, sets the flag and wakes on overflow
//- timer counts alike in normal, slow and green mode
//- prescale codes 000..111 divide the instruction clock by 256 down to 2
//- source select 0 picks instruction clock, 1 picks the 32K crystal
//- crystal source usable only with the internal RC with RTC option
//- in crystal mode a full 256 counts give a fixed half-second interval
//- in crystal mode prescale field is ignored; clock is 32768 Hz over 64
package bit_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MODE = 8'hB2;
  localparam logic [7:0] IDX_COUNT = 8'hB3;
  localparam logic [7:0] IDX_STATUS = 8'hB4;
  localparam logic [7:0] IDX_CLEAR = 8'hB5;
  localparam logic [7:0] IDX_ENABLE = 8'hB6;
  localparam int ADDR_W = 12;
  localparam logic [11:0] ADDR_MODE = {2'h0, IDX_MODE, 2'h0};
  localparam logic [11:0] ADDR_COUNT = {2'h0, IDX_COUNT, 2'h0};
  localparam logic [11:0] ADDR_STATUS = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] ADDR_CLEAR = {2'h0, IDX_CLEAR, 2'h0};
  localparam logic [11:0] ADDR_ENABLE = {2'h0, IDX_ENABLE, 2'h0};
  // Mode register fields
  localparam int MODE_RUN_BIT = 7;
  localparam int MODE_RATE_HI = 6;
  localparam int MODE_RATE_LO = 4;
  localparam int MODE_RTC_BIT = 0;
  // Event bit position shared by status, clear and enable registers
  localparam int EVT_OVF_BIT = 0;
  // Reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_FULL = 8'hFF;
  // Interrupt vector of the overflow
  localparam logic [15:0] IRQ_VECTOR = 16'h000B;
  // Prescaler widths and the crystal-mode division
  localparam int DIV_W = 9;
  localparam logic [8:0] DIV_SLOWEST = 9'h100;
  localparam int XTAL_HZ = 32768;
  localparam int RTC_DIVIDE = 64;
  localparam logic [8:0] RTC_DIV = 9'(RTC_DIVIDE);
endpackage : bit_pkg

// ===== core/bit_prescaler.sv
// Enable-pulse divider feeding the interval counter
`timescale 1ns/100ps
`default_nettype none
module bit_prescaler #(
  parameter int DIV_W = bit_pkg::DIV_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic src_tick,
  input wire logic run,
  input wire logic [DIV_W-1:0] divisor,
  output logic tick_out
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] last;

  // Terminal count; >= guards against a divisor shrunk mid-run
  assign last = divisor - DIV_W'(1);

  // Divider holds its phase while stopped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (run && src_tick) begin
      if (cnt_q >= last) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + DIV_W'(1);
      end
    end
  end

  // One-cycle timer clock enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= run && src_tick && (cnt_q >= last);
    end
  end
endmodule : bit_prescaler
`default_nettype wire

// ===== tb/bit_timer_sva.sv
// Port checker of the basic 8-bit interval timer
`timescale 1ns/100ps
`default_nettype none
module bit_timer_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic green_mode,
  input wire logic irq,
  input wire logic [15:0] irq_vector,
  input wire logic wake_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Writes that may lower the interrupt: flag clear or enable change
  wire logic clr_wr = psel && penable && pwrite &&
    (paddr == bit_pkg::ADDR_CLEAR || paddr == bit_pkg::ADDR_ENABLE);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  property p_ready; s_setup |=> s_access; endproperty
  property p_only; pready |-> psel && penable && $past(psel && !penable); endproperty
  property p_err; pslverr |-> pready; endproperty
  property p_idle; !pready |-> prdata == 32'h0; endproperty
  property p_vec; irq_vector == bit_pkg::IRQ_VECTOR; endproperty
  property p_wake; wake_req |=> !wake_req; endproperty
  property p_wgreen; wake_req |-> $past(green_mode); endproperty
  // Interrupt drops only two edges after a clear or mask write
  property p_clr; $fell(irq) |-> $past(clr_wr, 2); endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_only: assert property (p_only) else $error("stray ready");
  a_err: assert property (p_err) else $error("error without ready");
  a_idle: assert property (p_idle) else $error("read data outside access");
  a_vec: assert property (p_vec) else $error("wrong vector");
  a_wake: assert property (p_wake) else $error("wake too long");
  a_wgreen: assert property (p_wgreen) else $error("wake outside green");
  a_clr: assert property (p_clr) else $error("interrupt fell by itself");
endmodule : bit_timer_sva
bind bit_timer bit_timer_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .green_mode(green_mode), .irq(irq), .irq_vector(irq_vector),
  .wake_req(wake_req));
`default_nettype wire

// ===== tb/basic_8bit_interval_timer_tb.sv
// Self-checking bench of the basic 8-bit interval timer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin failures++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module basic_8bit_interval_timer_tb;
  localparam logic [11:0] mode_a = bit_pkg::ADDR_MODE;
  localparam logic [11:0] cnt_a = bit_pkg::ADDR_COUNT;
  localparam logic [11:0] stat_a = bit_pkg::ADDR_STATUS;
  localparam logic [11:0] clr_a = bit_pkg::ADDR_CLEAR;
  localparam logic [11:0] en_a = bit_pkg::ADDR_ENABLE;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic wake_req;
  logic [15:0] irq_vector;
  logic fcpu_tick = 1'b0;
  logic xtal32k_tick = 1'b0;
  logic green_mode = 1'b0;
  logic strap = 1'b0;
  logic [31:0] rd;
  logic err;
  int failures = 0;
  int tests_run = 0;
  int wakes = 0;
  bit_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fcpu_tick(fcpu_tick), .xtal32k_tick(xtal32k_tick),
    .green_mode(green_mode), .internal_rc_with_rtc_option(strap), .irq(irq),
    .irq_vector(irq_vector), .wake_req(wake_req));
  always #4 pclk = ~pclk;
  // Crystal ticks at half the rate, so a wrong source shows as a wrong interval
  always @(posedge pclk) begin
    fcpu_tick <= presetn;
    xtal32k_tick <= presetn & ~xtal32k_tick;
    wakes <= wakes + int'(wake_req === 1'b1);
  end
  task automatic end_of_test;
    $display("compares %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  // One APB transfer; idle cycle first so psel never toggles twice in a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 8);
    // Timeout ends the run; otherwise take the answer at the ready edge
    if (pready !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: no ready", $time);
      end_of_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  task automatic do_reset(input logic s);
    presetn <= 1'b0;
    strap <= s;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, mode_a, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, cnt_a, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, en_a, 32'h0);
    `CHK(rd, 32'h0)
    $display("test reset done");
  endtask : do_reset
  // Times one overflow from a loaded start value; cycles per count is dv
  task automatic interval(input logic [2:0] code, input logic rtc, input int k,
    input logic grn);
    int n = 0;
    int dv;
    int w0;
    dv = rtc ? 128 : (256 >> code);
    apb(1'b1, mode_a, {24'h0, 1'b0, code, 3'b000, rtc});
    apb(1'b0, mode_a, 32'h0);
    `CHK(rd, {24'h0, 1'b0, code, 3'b000, rtc})
    apb(1'b1, cnt_a, 32'(8'(256 - k)));
    apb(1'b1, clr_a, 32'h1);
    apb(1'b1, en_a, 32'h1);
    green_mode <= grn;
    w0 = wakes;
    apb(1'b1, mode_a, {24'h0, 1'b1, code, 3'b000, rtc});
    do begin
      @(posedge pclk);
      n++;
    end while (irq !== 1'b1 && n < k * dv + 64);
    // A missing overflow is a mismatch and closes the run
    if (irq !== 1'b1) begin
      failures++;
      $display("unexpected at %0t: no overflow interrupt", $time);
      end_of_test();
    end
    `CHK(n > (k - 1) * dv && n <= k * dv + 8, 1'b1)
    `CHK(wakes - w0, int'(grn))
    `CHK(irq_vector, bit_pkg::IRQ_VECTOR)
    apb(1'b1, mode_a, 32'h0);
    apb(1'b0, stat_a, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, en_a, 32'h0);
    repeat (3) @(posedge pclk);
    `CHK(irq, 1'b0)
    apb(1'b1, stat_a, 32'h0);
    apb(1'b0, stat_a, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, clr_a, 32'h1);
    apb(1'b0, stat_a, 32'h0);
    `CHK(rd, 32'h0)
    green_mode <= 1'b0;
    $display("test interval code %0d rtc %0d done", code, rtc);
  endtask : interval
  initial begin
    logic [7:0] v;
    void'($urandom(5710));
    do_reset(1'b0);
    apb(1'b1, mode_a, 32'h1);
    apb(1'b0, mode_a, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'b0, 12'h000, 32'h0);
    `CHK(err, 1'b1)
    // Stopped counter keeps a freshly written value while ticks run
    v = 8'($urandom);
    apb(1'b1, cnt_a, {24'h0, v});
    repeat (50) @(posedge pclk);
    apb(1'b0, cnt_a, 32'h0);
    `CHK(rd, {24'h0, v})
    $display("test hold done");
    // Load while running at divide-by-2: FE replaces a step, so wrap comes early
    apb(1'b1, cnt_a, 32'h0);
    apb(1'b1, mode_a, 32'h70);
    apb(1'b1, mode_a, 32'hF0);
    apb(1'b1, cnt_a, 32'hFE);
    repeat (12) @(posedge pclk);
    apb(1'b0, stat_a, 32'h0);
    `CHK(rd, 32'h1)
    apb(1'b1, mode_a, 32'h0);
    apb(1'b1, clr_a, 32'h1);
    $display("test running load done");
    for (int c = 0; c < 8; c++) interval(3'(c), 1'b0, 1 + int'($urandom % 3), c[0]);
    do_reset(1'b1);
    interval(3'($urandom), 1'b1, 256, 1'b1);
    end_of_test();
  end
endmodule : basic_8bit_interval_timer_tb
`default_nettype wire
